/* File: gtm_pkg.sv */
`default_nettype none
package gtm_pkg;
    typedef enum logic [1:0] {GTM_M32, GTM_MRTC, GTM_M16} gtm_mode_e;

    // Down-count with reload at zero, or forced load
    function automatic logic [15:0] gtm_dn16(input logic [15:0] c, input logic [15:0] l,
                                             input logic ld, input logic tk);
        gtm_dn16 = ld ? l : (tk ? ((c == 16'h0000) ? l : c - 16'h0001) : c);
    endfunction : gtm_dn16
endpackage : gtm_pkg
`default_nettype wire

/* File: gtm_presc.sv */
`timescale 1ns/100ps
`default_nettype none
module gtm_presc #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic reload,
    input wire logic [W-1:0] presc,
    output logic tick
);
    logic [W-1:0] pcnt;

    assign tick = run & (pcnt == '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt <= '0;
        end else if (reload) begin
            pcnt <= presc;
        end else if (run) begin
            pcnt <= (pcnt == '0) ? presc : pcnt - W'(1);
        end
    end

    a_presc_gap: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && presc != '0 && !reload) |=> !tick)
        else $error("prescaler ticked on consecutive cycles");
endmodule : gtm_presc
`default_nettype wire

/* File: gtm_regs.svh */
`ifndef GTM_REGS_SVH
`define GTM_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GTM_CFG_OFF 12'h000
`define GTM_AMR_OFF 12'h004
`define GTM_BMR_OFF 12'h008
`define GTM_CTL_OFF 12'h00C
`define GTM_IMR_OFF 12'h018
`define GTM_RIS_OFF 12'h01C
`define GTM_MIS_OFF 12'h020
`define GTM_ICR_OFF 12'h024
`define GTM_AILR_OFF 12'h028
`define GTM_BILR_OFF 12'h02C
`define GTM_AMATCH_OFF 12'h030
`define GTM_APR_OFF 12'h038
`define GTM_BPR_OFF 12'h03C
`define GTM_AVAL_OFF 12'h048
`define GTM_BVAL_OFF 12'h04C

// ----------------------------------------
// Field values and positions
// ----------------------------------------
`define GTM_CFG_32 3'h0
`define GTM_CFG_RTC 3'h1
`define GTM_CFG_16 3'h4
`define GTM_MR_ONESHOT 2'h1
`define GTM_MR_PERIODIC 2'h2
`define GTM_CTL_EN_A 0
`define GTM_CTL_STALL_A 1
`define GTM_CTL_RTC_RUN 4
`define GTM_CTL_TRIG_A 5
`define GTM_CTL_EN_B 8
`define GTM_CTL_STALL_B 9
`define GTM_CTL_TRIG_B 13
`define GTM_IRQ_TO_A 0
`define GTM_IRQ_RTC 3
`define GTM_IRQ_TO_B 8

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define GTM_LOAD_RST 16'hFFFF
`define GTM_PRESC_RST 8'h00
`define GTM_RTC_IN_HZ 32768
`define GTM_RTC_OUT_HZ 1

`endif

/* File: gtm_rtc_src.sv */
`timescale 1ns/100ps
`default_nettype none
// Reference clock on the even pin; stands low while idle
module gtm_rtc_src #(
    parameter int HALF = 3
) (
    input wire logic pclk,
    input wire logic run,
    output logic pin
);
    int cnt = 0;
    initial pin = 1'b0;
    always @(posedge pclk) begin
        if (!run) begin
            pin <= 1'b0;
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            pin <= ~pin;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : gtm_rtc_src
`default_nettype wire

/* File: gtm_rtcdiv.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gtm_regs.svh"
module gtm_rtcdiv #(
    parameter int DIV = `GTM_RTC_IN_HZ / `GTM_RTC_OUT_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic clk_in,
    output logic tick
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt;
    logic prev;
    wire rise = clk_in & ~prev;
    wire last = (cnt == CW'(DIV - 1));

    // Pin is sampled as a plain input; one edge per reference cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= 1'b0;
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            prev <= clk_in;
            tick <= run & rise & last;
            if (!run) begin
                cnt <= '0;
            end else if (rise) begin
                cnt <= last ? '0 : cnt + CW'(1);
            end
        end
    end

    a_sec_single: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> !tick)
        else $error("seconds tick wider than one cycle");
endmodule : gtm_rtcdiv
`default_nettype wire

/* File: gtm_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gtm_regs.svh"
module gtm_top #(
    parameter int RTC_DIV = `GTM_RTC_IN_HZ / `GTM_RTC_OUT_HZ,
    parameter int PW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_compare_pin_even,
    output logic trig_a,
    output logic trig_b,
    output logic irq
);
    import gtm_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [2:0] width_config_reg;
    logic [1:0] counter_a_mode_field;
    logic [1:0] counter_b_mode_field;
    logic counter_a_enable, counter_a_stall_enable, rtc_run_enable, counter_a_trigger_enable;
    logic counter_b_enable, counter_b_stall_enable, counter_b_trigger_enable;
    logic counter_a_timeout_mask, rtc_match_mask, counter_b_timeout_mask;
    logic counter_a_timeout_raw, rtc_match_raw, counter_b_timeout_raw;
    logic [15:0] counter_a_interval_load, counter_b_interval_load;
    logic [31:0] counter_a_match_reg;
    logic [PW-1:0] counter_a_prescale, counter_b_prescale;
    logic [15:0] counter_a_value, counter_b_value;
    logic pend_a, pend_b, rtc_seen;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire s_cfg = paddr == `GTM_CFG_OFF;
    wire s_amr = paddr == `GTM_AMR_OFF;
    wire s_bmr = paddr == `GTM_BMR_OFF;
    wire s_ctl = paddr == `GTM_CTL_OFF;
    wire s_imr = paddr == `GTM_IMR_OFF;
    wire s_ris = paddr == `GTM_RIS_OFF;
    wire s_mis = paddr == `GTM_MIS_OFF;
    wire s_icr = paddr == `GTM_ICR_OFF;
    wire s_ailr = paddr == `GTM_AILR_OFF;
    wire s_bilr = paddr == `GTM_BILR_OFF;
    wire s_amat = paddr == `GTM_AMATCH_OFF;
    wire s_apr = paddr == `GTM_APR_OFF;
    wire s_bpr = paddr == `GTM_BPR_OFF;
    wire s_aval = paddr == `GTM_AVAL_OFF;
    wire s_bval = paddr == `GTM_BVAL_OFF;
    wire mapped = s_cfg | s_amr | s_bmr | s_ctl | s_imr | s_ris | s_mis | s_icr
                | s_ailr | s_bilr | s_amat | s_apr | s_bpr | s_aval | s_bval;
    // Unmapped writes are dropped and flagged by pslverr
    wire wr_cfg = wr & s_cfg;
    wire wr_ctl = wr & s_ctl;
    wire wr_icr = wr & s_icr;
    wire wr_ailr = wr & s_ailr;
    wire wr_bilr = wr & s_bilr;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    wire gtm_mode_e mode = (width_config_reg == `GTM_CFG_16) ? GTM_M16 :
                           (width_config_reg == `GTM_CFG_RTC) ? GTM_MRTC : GTM_M32;
    wire m16 = mode == GTM_M16;
    wire mrtc = mode == GTM_MRTC;
    wire m32 = mode == GTM_M32;
    wire [31:0] cnt32 = {counter_b_value, counter_a_value};
    wire [31:0] ilr32 = {counter_b_interval_load, counter_a_interval_load};
    wire stall_a = counter_a_stall_enable & ~rtc_run_enable;
    wire stall_b = counter_b_stall_enable & ~rtc_run_enable;
    wire oneshot_a = counter_a_mode_field == `GTM_MR_ONESHOT;
    wire oneshot_b = counter_b_mode_field == `GTM_MR_ONESHOT;

    // ----------------------------------------
    // Chained counting
    // ----------------------------------------
    // Counter B mode, control and prescale fields are ignored when chained; a BILR write still sets the upper load half
    wire run32 = m32 & counter_a_enable & ~stall_a;
    wire hit32 = run32 & (cnt32 == 32'h0000_0000);
    wire pend32 = m32 & (pend_a | pend_b);
    wire sec_tick;
    wire rtc_step = sec_tick & mrtc & counter_a_enable;
    wire rtc_hit = rtc_step & (cnt32 == counter_a_match_reg);
    wire rtc_first = wr_cfg & (pwdata[2:0] == `GTM_CFG_RTC) & ~rtc_seen;
    wire [31:0] next_cnt32 = rtc_first ? 32'h0000_0001 :
                             pend32 ? ilr32 :
                             rtc_step ? (rtc_hit ? 32'h0000_0000 : cnt32 + 32'h0000_0001) :
                             hit32 ? ilr32 :
                             run32 ? cnt32 - 32'h0000_0001 : cnt32;

    // ----------------------------------------
    // Split counting
    // ----------------------------------------
    wire run_a16 = m16 & counter_a_enable & ~stall_a;
    wire run_b16 = m16 & counter_b_enable & ~stall_b;
    wire tick_a, tick_b;
    wire hit_a16 = tick_a & (counter_a_value == 16'h0000);
    wire hit_b16 = tick_b & (counter_b_value == 16'h0000);
    wire [15:0] next_a16 = gtm_dn16(counter_a_value, counter_a_interval_load, pend_a, tick_a);
    wire [15:0] next_b16 = gtm_dn16(counter_b_value, counter_b_interval_load, pend_b, tick_b);
    wire hit_a = hit32 | hit_a16;
    wire hit_b = hit_b16;
    wire use16 = m16 & ~rtc_first;

    gtm_presc #(.W(PW)) u_presc_a (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_a16),
        .reload(pend_a),
        .presc(counter_a_prescale),
        .tick(tick_a)
    );

    gtm_presc #(.W(PW)) u_presc_b (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_b16),
        .reload(pend_b),
        .presc(counter_b_prescale),
        .tick(tick_b)
    );

    // Only the even pin is used; odd pins serve capture modes not built here
    gtm_rtcdiv #(.DIV(RTC_DIV)) u_rtcdiv (
        .pclk(pclk),
        .presetn(presetn),
        .run(mrtc & counter_a_enable),
        .clk_in(capture_compare_pin_even),
        .tick(sec_tick)
    );

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire [31:0] ris_word = (32'(counter_a_timeout_raw) << `GTM_IRQ_TO_A)
                         | (32'(rtc_match_raw) << `GTM_IRQ_RTC)
                         | (32'(counter_b_timeout_raw) << `GTM_IRQ_TO_B);
    wire [31:0] imr_word = (32'(counter_a_timeout_mask) << `GTM_IRQ_TO_A)
                         | (32'(rtc_match_mask) << `GTM_IRQ_RTC)
                         | (32'(counter_b_timeout_mask) << `GTM_IRQ_TO_B);
    wire [31:0] ctl_word = (32'(counter_a_enable) << `GTM_CTL_EN_A)
                         | (32'(counter_a_stall_enable) << `GTM_CTL_STALL_A)
                         | (32'(rtc_run_enable) << `GTM_CTL_RTC_RUN)
                         | (32'(counter_a_trigger_enable) << `GTM_CTL_TRIG_A)
                         | (32'(counter_b_enable) << `GTM_CTL_EN_B)
                         | (32'(counter_b_stall_enable) << `GTM_CTL_STALL_B)
                         | (32'(counter_b_trigger_enable) << `GTM_CTL_TRIG_B);
    wire [31:0] rd_mux = s_cfg ? 32'(width_config_reg) :
                         s_amr ? 32'(counter_a_mode_field) :
                         s_bmr ? 32'(counter_b_mode_field) :
                         s_ctl ? ctl_word :
                         s_imr ? imr_word :
                         s_ris ? ris_word :
                         s_mis ? (ris_word & imr_word) :
                         s_ailr ? (m16 ? 32'(counter_a_interval_load) : ilr32) :
                         s_bilr ? 32'(counter_b_interval_load) :
                         s_amat ? counter_a_match_reg :
                         s_apr ? 32'(counter_a_prescale) :
                         s_bpr ? 32'(counter_b_prescale) :
                         s_aval ? (m16 ? 32'(counter_a_value) : cnt32) :
                         s_bval ? 32'(counter_b_value) : 32'h0000_0000;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    // Data captured in setup so prdata stays a flop output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel & ~penable) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // ----------------------------------------
    // Configuration and control
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width_config_reg <= 3'h0;
            counter_a_mode_field <= 2'h0;
            counter_b_mode_field <= 2'h0;
            counter_a_stall_enable <= 1'b0;
            rtc_run_enable <= 1'b0;
            counter_a_trigger_enable <= 1'b0;
            counter_b_stall_enable <= 1'b0;
            counter_b_trigger_enable <= 1'b0;
            counter_a_timeout_mask <= 1'b0;
            rtc_match_mask <= 1'b0;
            counter_b_timeout_mask <= 1'b0;
            counter_a_match_reg <= 32'h0000_0000;
            counter_a_prescale <= PW'(`GTM_PRESC_RST);
            counter_b_prescale <= PW'(`GTM_PRESC_RST);
            rtc_seen <= 1'b0;
        end else begin
            if (wr_cfg) width_config_reg <= pwdata[2:0];
            if (rtc_first) rtc_seen <= 1'b1;
            if (wr & s_amr) counter_a_mode_field <= pwdata[1:0];
            if (wr & s_bmr) counter_b_mode_field <= pwdata[1:0];
            if (wr_ctl) begin
                counter_a_stall_enable <= pwdata[`GTM_CTL_STALL_A];
                rtc_run_enable <= pwdata[`GTM_CTL_RTC_RUN];
                counter_a_trigger_enable <= pwdata[`GTM_CTL_TRIG_A];
                counter_b_stall_enable <= pwdata[`GTM_CTL_STALL_B];
                counter_b_trigger_enable <= pwdata[`GTM_CTL_TRIG_B];
            end
            if (wr & s_imr) begin
                counter_a_timeout_mask <= pwdata[`GTM_IRQ_TO_A];
                rtc_match_mask <= pwdata[`GTM_IRQ_RTC];
                counter_b_timeout_mask <= pwdata[`GTM_IRQ_TO_B];
            end
            if (wr & s_amat) counter_a_match_reg <= pwdata;
            if (wr & s_apr) counter_a_prescale <= pwdata[PW-1:0];
            if (wr & s_bpr) counter_b_prescale <= pwdata[PW-1:0];
        end
    end

    // Software write to control wins over the one-shot clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_a_enable <= 1'b0;
            counter_b_enable <= 1'b0;
        end else begin
            counter_a_enable <= wr_ctl ? pwdata[`GTM_CTL_EN_A] : counter_a_enable & ~(hit_a & oneshot_a);
            counter_b_enable <= wr_ctl ? pwdata[`GTM_CTL_EN_B] : counter_b_enable & ~(hit_b & oneshot_b);
        end
    end

    // ----------------------------------------
    // Load registers and counters
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_a_interval_load <= `GTM_LOAD_RST;
            counter_b_interval_load <= `GTM_LOAD_RST;
            counter_a_value <= `GTM_LOAD_RST;
            counter_b_value <= `GTM_LOAD_RST;
            pend_a <= 1'b0;
            pend_b <= 1'b0;
        end else begin
            if (wr_ailr) begin
                counter_a_interval_load <= pwdata[15:0];
                if (!m16) counter_b_interval_load <= pwdata[31:16];
            end else if (wr_bilr) begin
                counter_b_interval_load <= pwdata[15:0];
            end
            pend_a <= wr_ailr;
            pend_b <= wr_bilr;
            counter_a_value <= use16 ? next_a16 : next_cnt32[15:0];
            counter_b_value <= use16 ? next_b16 : next_cnt32[31:16];
        end
    end

    // ----------------------------------------
    // Flags, trigger and interrupt
    // ----------------------------------------
    // A new event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_a_timeout_raw <= 1'b0;
            rtc_match_raw <= 1'b0;
            counter_b_timeout_raw <= 1'b0;
            trig_a <= 1'b0;
            trig_b <= 1'b0;
            irq <= 1'b0;
        end else begin
            counter_a_timeout_raw <= hit_a | (counter_a_timeout_raw & ~(wr_icr & pwdata[`GTM_IRQ_TO_A]));
            rtc_match_raw <= rtc_hit | (rtc_match_raw & ~(wr_icr & pwdata[`GTM_IRQ_RTC]));
            counter_b_timeout_raw <= hit_b | (counter_b_timeout_raw & ~(wr_icr & pwdata[`GTM_IRQ_TO_B]));
            trig_a <= hit_a & counter_a_trigger_enable;
            trig_b <= hit_b & counter_b_trigger_enable;
            irq <= |(ris_word & imr_word);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_trig_one_cycle: assert property (trig_a |=> !trig_a)
        else $error("trigger pulse longer than one cycle");
    a_trig_at_zero: assert property ((hit32 && counter_a_trigger_enable) |=> trig_a ##1 !trig_a)
        else $error("no single trigger pulse after zero");
    a_oneshot_stop: assert property ((hit_a && oneshot_a && !wr_ctl) |=> !counter_a_enable ##1 !hit_a)
        else $error("one-shot counter kept running");
    a_reload_value: assert property ((hit32 && !pend32 && !rtc_first) |=> cnt32 == $past(ilr32))
        else $error("chained counter did not reload");
    a_load_rewrite: assert property ((wr_ailr && m32 && !wr_cfg) |=> ##1 cnt32 == $past(pwdata, 2))
        else $error("rewritten load not taken next cycle");
    a_stall_freeze: assert property ((m32 && stall_a && !pend32 && !rtc_first) |=> $stable(cnt32))
        else $error("stalled counter moved");
    a_timeout_hold: assert property ((counter_a_timeout_raw && !wr_icr) |=> counter_a_timeout_raw)
        else $error("time-out flag dropped without clear");
    a_rtc_roll: assert property ((rtc_hit && !rtc_first && !pend32) |=> cnt32 == 32'h0000_0000 && rtc_match_raw)
        else $error("clock match did not roll over");
    a_rtc_first_load: assert property (rtc_first |=> cnt32 == 32'h0000_0001)
        else $error("first clock selection did not load one");

    // ----------------------------------------
    // Split, chained and clock-mode checks
    // ----------------------------------------
    a_concat_load: assert property ((wr_ailr && !m16) |=> ilr32 == $past(pwdata))
        else $error("chained load write did not fill both halves");
    a_split_b_load: assert property ((wr_ailr && m16) |=> $stable(counter_b_interval_load))
        else $error("split load write touched counter B load");
    a_presc_hold: assert property ((m16 && !pend_a && !tick_a && !rtc_first) |=> $stable(counter_a_value))
        else $error("split counter moved without a prescaler tick");
    a_hold_stopped: assert property ((m32 && !counter_a_enable && !pend32 && !wr_cfg) |=> $stable(cnt32))
        else $error("disabled chained counter moved");
    a_rtc_count_up: assert property ((rtc_step && !rtc_hit && !wr_cfg && !pend32) |=> cnt32 == $past(cnt32) + 32'h0000_0001)
        else $error("clock counter did not count up");
    a_rtc_ignore_stall: assert property ((rtc_step && rtc_run_enable && counter_a_stall_enable && !rtc_hit && !wr_cfg && !pend32) |=> cnt32 == $past(cnt32) + 32'h0000_0001)
        else $error("clock counter froze under stall");
    a_flag_clear: assert property ((wr_icr && pwdata[`GTM_IRQ_TO_A] && !hit_a) |=> !counter_a_timeout_raw)
        else $error("time-out flag not cleared by write of one");
    a_irq_follow: assert property ((|(ris_word & imr_word)) |=> irq)
        else $error("interrupt missing for unmasked flag");
    a_trig_b_pulse: assert property (trig_b |=> !trig_b)
        else $error("counter B trigger longer than one cycle");
    a_trig_b_zero: assert property ((hit_b && counter_b_trigger_enable) |=> trig_b)
        else $error("counter B trigger missing at zero");
    a_oneshot_b_stop: assert property ((hit_b && oneshot_b && !wr_ctl) |=> !counter_b_enable)
        else $error("one-shot counter B kept its enable");
    a_b_count_down: assert property ((tick_b && !pend_b && !wr_cfg && counter_b_value != 16'h0000) |=> counter_b_value == $past(counter_b_value) - 16'h0001)
        else $error("split counter B did not count down");
endmodule : gtm_top
`default_nettype wire

/* File: tb_dual_16bit_timer_rtc_block.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gtm_regs.svh"
module tb_dual_16bit_timer_rtc_block;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trig_a, trig_b, irq, rtc_run, rtc_pin, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    int n_fail = 0;
    int checked = 0;
    int g;

    // Divider shortened so a second of counting fits in a few dozen cycles
    gtm_top #(.RTC_DIV(4), .PW(8)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_compare_pin_even(rtc_pin), .trig_a(trig_a), .trig_b(trig_b), .irq(irq));
    gtm_rtc_src #(.HALF(3)) i_src (.pclk(pclk), .run(rtc_run), .pin(rtc_pin));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic report_and_stop;
        $display("counts: checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task automatic wait_trig;
        int n;
        n = 0;
        while (trig_a !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400) n_fail++;
        @(posedge pclk);
        chk({31'h0, trig_a}, 32'h0);
    endtask : wait_trig

    // Cycles from one trigger pulse to the next
    task automatic gap(output int c);
        wait_trig();
        c = 1;
        while (trig_a !== 1'b1 && c < 400) begin
            @(posedge pclk);
            c++;
        end
    endtask : gap

    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        rtc_run = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`GTM_CTL_OFF, 32'h0);
        rdc(`GTM_AILR_OFF, 32'hFFFFFFFF);
        rdc(`GTM_AVAL_OFF, 32'hFFFFFFFF);
        rdc(`GTM_APR_OFF, 32'h0);
        rdc(`GTM_BPR_OFF, 32'h0);
        rdc(12'h0FC, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(`GTM_AILR_OFF, 32'h00030004);
        rdc(`GTM_BILR_OFF, 32'h3);
        rdc(`GTM_AVAL_OFF, 32'h00030004);
        $display("test reset and concat done");
        wr(`GTM_AMR_OFF, 32'h1);
        wr(`GTM_AILR_OFF, 32'h5);
        wr(`GTM_IMR_OFF, 32'h1);
        wr(`GTM_CTL_OFF, 32'h21);
        wait_trig();
        rdc(`GTM_CTL_OFF, 32'h20);
        rdc(`GTM_AVAL_OFF, 32'h5);
        rdc(`GTM_RIS_OFF, 32'h1);
        rdc(`GTM_MIS_OFF, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`GTM_ICR_OFF, 32'h0);
        rdc(`GTM_RIS_OFF, 32'h1);
        wr(`GTM_ICR_OFF, 32'h1);
        rdc(`GTM_RIS_OFF, 32'h0);
        $display("test one-shot done");
        wr(`GTM_AMR_OFF, 32'h2);
        wr(`GTM_AILR_OFF, 32'h3);
        wr(`GTM_CTL_OFF, 32'h21);
        gap(g);
        chk(g, 32'h4);
        rdc(`GTM_CTL_OFF, 32'h21);
        wr(`GTM_CTL_OFF, 32'h23);
        apb(1'b0, `GTM_AVAL_OFF, 32'h0);
        v = rd;
        repeat (5) @(posedge pclk);
        rdc(`GTM_AVAL_OFF, v);
        wr(`GTM_CTL_OFF, 32'h0);
        wr(`GTM_AILR_OFF, 32'h100);
        rdc(`GTM_AVAL_OFF, 32'h100);
        $display("test periodic done");
        wr(`GTM_CFG_OFF, 32'h4);
        wr(`GTM_APR_OFF, 32'h2);
        rdc(`GTM_APR_OFF, 32'h2);
        wr(`GTM_AILR_OFF, 32'h5);
        wr(`GTM_CTL_OFF, 32'h21);
        gap(g);
        chk(g, 32'd18);
        wr(`GTM_CTL_OFF, 32'h0);
        wr(`GTM_BMR_OFF, 32'h1);
        wr(`GTM_BILR_OFF, 32'h2);
        wr(`GTM_CTL_OFF, 32'h2100);
        g = 0;
        while (trig_b !== 1'b1 && g < 400) begin
            @(posedge pclk);
            g++;
        end
        chk(g, 32'd4);
        rdc(`GTM_CTL_OFF, 32'h2000);
        rdc(`GTM_RIS_OFF, 32'h101);
        $display("test split prescale done");
        wr(`GTM_ICR_OFF, 32'h109);
        wr(`GTM_IMR_OFF, 32'h8);
        wr(`GTM_CFG_OFF, 32'h1);
        rdc(`GTM_AVAL_OFF, 32'h1);
        wr(`GTM_AMATCH_OFF, 32'h3);
        rtc_run <= 1'b1;
        wr(`GTM_CTL_OFF, 32'h11);
        g = 0;
        while (irq !== 1'b1 && g < 600) begin
            @(posedge pclk);
            g++;
        end
        if (g >= 600) n_fail++;
        rdc(`GTM_RIS_OFF, 32'h8);
        rdc(`GTM_AVAL_OFF, 32'h0);
        wr(`GTM_ICR_OFF, 32'h8);
        rdc(`GTM_RIS_OFF, 32'h0);
        wr(`GTM_CTL_OFF, 32'h213);
        repeat (60) @(posedge pclk);
        apb(1'b0, `GTM_AVAL_OFF, 32'h0);
        chk({31'h0, rd != 32'h0}, 32'h1);
        $display("test clock mode done");
        report_and_stop();
    end
endmodule : tb_dual_16bit_timer_rtc_block
`default_nettype wire
